// *** design/dapc_pkg.sv ***
// dapc_pkg: constants, register map and carrier types of the output path config bank
package dapc_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int DAPC_REG_W    = 16;
   localparam int DAPC_ADDR_W   = 8;
   localparam int DAPC_FRAME_W  = 24;
   localparam int DAPC_RES_W    = 18;
   localparam int DAPC_WORD_W   = 24;
   localparam int DAPC_TAG_W    = 8;
   localparam int DAPC_TEMP_W   = 10;
   localparam int DAPC_NUM_REGS = 14;
   localparam int DAPC_IDX_W    = 4;

   // ------------------------------------------------------------
   // register indices, offsets and reset values
   // ------------------------------------------------------------
   localparam logic [3:0] IDX_FMT = 4'h0, IDX_LANE = 4'h1, IDX_PCA = 4'h2, IDX_P0A = 4'h3;
   localparam logic [3:0] IDX_SHA = 4'h4, IDX_P1A = 4'h5, IDX_PCB = 4'h6, IDX_P0B = 4'h7;
   localparam logic [3:0] IDX_SHB = 4'h8, IDX_TAG = 4'h9, IDX_GTU = 4'hA, IDX_TRG = 4'hB;
   localparam logic [3:0] IDX_TMP = 4'hC, IDX_CLK = 4'hD;
   localparam logic [7:0] DAPC_OFFSET [DAPC_NUM_REGS] = '{
      8'h0D, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18,
      8'h19, 8'h1A, 8'h1C, 8'h33, 8'h90, 8'h91, 8'hC0};
   localparam logic [15:0] FMT_RESET  = 16'h2002;
   localparam logic [15:0] LANE_RESET = 16'h0002;
   localparam logic [15:0] ZERO_RESET = 16'h0000;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int FMT_TWOS_BIT = 13;
   localparam int GT1_BIT      = 7;
   localparam int AVG_ON_BIT   = 6;
   localparam int AVG_DEP_LSB  = 2;
   localparam int SCR_BIT      = 3;
   localparam int LANES_LSB    = 0;
   localparam int STEP_LSB     = 4;
   localparam int KIND_LSB     = 2;
   localparam int PAT_ON_BIT   = 1;
   localparam int GT3_BIT      = 13;
   localparam int GT2_BIT      = 6;
   localparam int KEY_LSB      = 4;
   localparam int TRIG_BIT     = 14;
   localparam int LCLK_BIT     = 12;
   localparam int PREP_LSB     = 10;
   localparam int OCLK_LSB     = 7;
   localparam int SLEEP_A_BIT  = 0;
   localparam int SLEEP_B_BIT  = 1;

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [1:0] KEY_OPEN     = 2'h3;
   localparam logic [2:0] LANES_2X20   = 3'h0;
   localparam logic [2:0] LANES_2X24   = 3'h2;
   localparam logic [2:0] LANES_1X20   = 3'h5;
   localparam logic [2:0] LANES_1X24   = 3'h7;
   localparam logic [1:0] KIND_RAMP    = 2'h2;
   localparam logic [1:0] KIND_ALT     = 2'h3;
   localparam logic [7:0] READ_CMD     = 8'hFE;
   localparam logic [6:0] BITS_20      = 7'h1C;  // 20 data + 8 tag
   localparam logic [6:0] BITS_24      = 7'h20;  // 24 data + 8 tag

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic {SER_IDLE, SER_SEND} dapc_ser_state_t;

   typedef struct packed {
      logic [DAPC_ADDR_W-1:0] addr;
      logic [DAPC_REG_W-1:0]  data;
   } dapc_frame_t;

   typedef struct packed {
      logic [DAPC_WORD_W-1:0] data;
      logic [DAPC_TAG_W-1:0]  tag;
   } dapc_lane_word_t;

endpackage : dapc_pkg

// *** design/dapc_output_path_bank.sv ***
// dapc_output_path_bank: config bank, serial config port and output word path
`timescale 1ns/100ps
//
// Contract
// - format bit: 0 straight binary, 1 twos-complement
// - averaging only while averaging-on bit set
// - depth codes 0..3 average 2,4,8,16
// - any gain trim enable turns calibration on
// - scramble: XOR output bits above the LSB with result LSB
// - lane layouts 0,2,5,7 select lanes and width
// - pattern-on replaces each channel's result with that channel's pattern
// - kind: 0/1 fixed zero, 2 ramp, 3 alternate
// - ramp advances by step plus one
// - pattern zero: low word plus shared low byte
// - pattern one: shared high byte plus high word
// - channel B has its own pattern set, but its pattern one high word is fixed at zero
// - append eight-bit tag, B high byte, A low
// - rising trigger bit loads temperature reading
// - temperature reading is ten low bits
// - three-bit averaging output clock field
// - sleep field: 0 none,1 A,2 B,3 both
module dapc_output_path_bank
   import dapc_pkg::*;
#(
   parameter int RES_W = DAPC_RES_W
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // serial configuration port (pins)
   input  wire logic                    cfg_cs_n,
   input  wire logic                    cfg_sclk,
   input  wire logic                    cfg_sdi,
   output logic                         cfg_sdo,
   // conversion results, same clock
   input  wire logic                    conv_valid,
   input  wire logic [RES_W-1:0]        conv_a,
   input  wire logic [RES_W-1:0]        conv_b,
   input  wire logic [DAPC_TEMP_W-1:0]  temp_sensor,
   // serial data lanes
   output logic                         lane_a_out,
   output logic                         lane_b_out,
   output logic                         frame_out,
   // control levels to the analog side
   output logic                         gain_trim_on,
   output logic                         init_unlocked,
   output logic                         sleep_a,
   output logic                         sleep_b,
   output logic                         lane_clock_cfg,
   output logic [1:0]                   averaging_prep,
   output logic [2:0]                   averaging_out_clock_cfg
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] cs_sync, sclk_sync, sdi_sync;
   logic       cs_prev, sclk_prev;

   // two stages per pin; only stage 1 output is used by logic
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cs_sync   <= 2'h3;
         sclk_sync <= 2'h0;
         sdi_sync  <= 2'h0;
         cs_prev   <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         cs_sync   <= {cs_sync[0], cfg_cs_n};
         sclk_sync <= {sclk_sync[0], cfg_sclk};
         sdi_sync  <= {sdi_sync[0], cfg_sdi};
         cs_prev   <= cs_sync[1];
         sclk_prev <= sclk_sync[1];
      end
   end

   logic cs_act, sclk_rise, sclk_fall, frame_end;
   assign cs_act    = ~cs_sync[1];
   assign sclk_rise = cs_act & sclk_sync[1] & ~sclk_prev;
   assign sclk_fall = cs_act & ~sclk_sync[1] & sclk_prev;
   assign frame_end = cs_sync[1] & ~cs_prev;

   // ------------------------------------------------------------
   // configuration frame shifter
   // ------------------------------------------------------------
   dapc_frame_t rx_frame;
   logic [4:0]  rx_count;
   logic [DAPC_FRAME_W-1:0] rd_shift;
   logic        frame_full;
   assign frame_full = (rx_count == 5'(DAPC_FRAME_W));

   // msb first; extra bits past 24 are ignored rather than wrapping
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_frame <= '0;
         rx_count <= 5'h00;
      end else if (frame_end) begin
         rx_count <= 5'h00;
      end else if (sclk_rise && !frame_full) begin
         rx_frame <= {rx_frame[DAPC_FRAME_W-2:0], sdi_sync[1]};
         rx_count <= rx_count + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [DAPC_REG_W-1:0] regs [DAPC_NUM_REGS];
   logic                  hit;
   logic [DAPC_IDX_W-1:0] hit_idx;
   logic [DAPC_ADDR_W-1:0] look_addr;
   logic                  is_read_cmd;

   assign is_read_cmd = (rx_frame.addr == READ_CMD);
   // a read command names the target in its low byte
   assign look_addr = is_read_cmd ? rx_frame.data[DAPC_ADDR_W-1:0] : rx_frame.addr;

   // address decode against the offset table
   always_comb begin
      hit     = 1'b0;
      hit_idx = '0;
      for (int i = 0; i < DAPC_NUM_REGS; i++) begin
         if (DAPC_OFFSET[i] == look_addr) begin
            hit     = 1'b1;
            hit_idx = DAPC_IDX_W'(i);
         end
      end
   end

   logic wr_en, trig_rise;
   assign wr_en     = frame_end & frame_full & ~is_read_cmd & hit;
   // load on a 0 to 1 transition of the trigger bit only
   assign trig_rise = wr_en & (hit_idx == IDX_TRG) & rx_frame.data[TRIG_BIT]
                    & ~regs[IDX_TRG][TRIG_BIT];

   // writes land whole; unmapped addresses are dropped silently
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < DAPC_NUM_REGS; i++) begin
            regs[i] <= ZERO_RESET;
         end
         regs[IDX_FMT]  <= FMT_RESET;
         regs[IDX_LANE] <= LANE_RESET;
      end else begin
         if (wr_en) begin
            regs[hit_idx] <= rx_frame.data;
         end
         // the sensor load wins over a write to the reading register
         if (trig_rise) begin
            regs[IDX_TMP] <= {{(DAPC_REG_W-DAPC_TEMP_W){1'b0}}, temp_sensor};
         end
      end
   end

   // readback: a read command loads {addr, data}, the next frame shifts it out
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_shift <= '0;
      end else if (frame_end) begin
         rd_shift <= (frame_full && is_read_cmd && hit) ? {look_addr, regs[hit_idx]} : '0;
      end else if (sclk_fall) begin
         rd_shift <= {rd_shift[DAPC_FRAME_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_sdo <= 1'b0;
      end else begin
         cfg_sdo <= cs_act & rd_shift[DAPC_FRAME_W-1];
      end
   end

   // ------------------------------------------------------------
   // control outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gain_trim_on            <= 1'b0;
         init_unlocked           <= 1'b0;
         sleep_a                 <= 1'b0;
         sleep_b                 <= 1'b0;
         lane_clock_cfg          <= 1'b0;
         averaging_prep          <= 2'h0;
         averaging_out_clock_cfg <= 3'h0;
      end else begin
         gain_trim_on   <= regs[IDX_FMT][GT1_BIT] | regs[IDX_GTU][GT2_BIT]
                         | regs[IDX_GTU][GT3_BIT];
         // the key itself is the host's to write; the device only reports it
         init_unlocked  <= (regs[IDX_GTU][KEY_LSB+:2] == KEY_OPEN);
         sleep_a        <= regs[IDX_CLK][SLEEP_A_BIT];
         sleep_b        <= regs[IDX_CLK][SLEEP_B_BIT];
         lane_clock_cfg <= regs[IDX_CLK][LCLK_BIT];
         averaging_prep <= regs[IDX_CLK][PREP_LSB+:2];
         averaging_out_clock_cfg <= regs[IDX_CLK][OCLK_LSB+:3];
      end
   end

   // ------------------------------------------------------------
   // averaging control, shared by both channels
   // ------------------------------------------------------------
   logic       avg_on, twos, scramble;
   logic [1:0] depth;
   logic [4:0] avg_cnt, avg_last;
   logic       avg_fire;
   assign avg_on   = regs[IDX_FMT][AVG_ON_BIT];
   assign depth    = regs[IDX_FMT][AVG_DEP_LSB+:2];
   assign twos     = regs[IDX_FMT][FMT_TWOS_BIT];
   assign scramble = regs[IDX_LANE][SCR_BIT];
   // 2 << depth samples, so the last index is that minus one
   assign avg_last = 5'((5'h02 << depth) - 5'h01);
   assign avg_fire = conv_valid & (~avg_on | (avg_cnt == avg_last));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avg_cnt <= 5'h00;
      end else if (conv_valid) begin
         avg_cnt <= (avg_fire || !avg_on) ? 5'h00 : avg_cnt + 5'h01;
      end
   end

   // per-channel pattern fields gathered for the generate loop
   logic [DAPC_REG_W-1:0]  pat_ctrl [2];
   logic [DAPC_WORD_W-1:0] pat_zero [2];
   logic [DAPC_WORD_W-1:0] pat_one  [2];
   assign pat_ctrl[0] = regs[IDX_PCA];
   assign pat_ctrl[1] = regs[IDX_PCB];
   assign pat_zero[0] = {regs[IDX_SHA][7:0], regs[IDX_P0A]};
   assign pat_zero[1] = {regs[IDX_SHB][7:0], regs[IDX_P0B]};
   assign pat_one[0]  = {regs[IDX_P1A], regs[IDX_SHA][15:8]};
   // the upper word of channel B pattern one is not held in this bank
   assign pat_one[1]  = {16'h0000, regs[IDX_SHB][15:8]};

   dapc_lane_word_t lane_word [2];

   // ------------------------------------------------------------
   // per-channel average, format, scramble, pattern and tag
   // ------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      localparam int ACC_W = RES_W + 4;
      logic signed [ACC_W-1:0] acc, sum;
      logic [RES_W-1:0]        sample, avg_res, res;
      logic [DAPC_WORD_W-1:0]  ramp, pat;
      logic                    alt_sel;

      assign sample = (c == 0) ? conv_a : conv_b;
      assign sum    = acc + ACC_W'(signed'(sample));
      // arithmetic shift divides the sum by the sample count
      // shift amount held at 3 bits so that depth 3 gives a shift of 4, not a wrap to 0
      assign avg_res = avg_on ? RES_W'(sum >>> (3'(depth) + 3'h1)) : sample;

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            acc <= '0;
         end else if (conv_valid) begin
            acc <= (avg_fire || !avg_on) ? '0 : sum;
         end
      end

      // format then scramble; the LSB is left unscrambled so the receiver can undo it
      always_comb begin
         res = avg_res;
         if (!twos) begin
            res[RES_W-1] = ~res[RES_W-1];
         end
         if (scramble) begin
            res[RES_W-1:1] = res[RES_W-1:1] ^ {(RES_W-1){avg_res[0]}};
         end
      end

      // pattern state advances once per delivered sample
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            ramp    <= '0;
            alt_sel <= 1'b0;
         end else if (avg_fire) begin
            ramp    <= ramp + DAPC_WORD_W'(pat_ctrl[c][STEP_LSB+:4]) + 24'h000001;
            alt_sel <= ~alt_sel;
         end
      end

      always_comb begin
         unique case (pat_ctrl[c][KIND_LSB+:2])
            KIND_RAMP: pat = ramp;
            KIND_ALT:  pat = alt_sel ? pat_one[c] : pat_zero[c];
            default:   pat = pat_zero[c];
         endcase
      end

      assign lane_word[c].data = pat_ctrl[c][PAT_ON_BIT] ? pat
                               : {res, {(DAPC_WORD_W-RES_W){1'b0}}};
      assign lane_word[c].tag  = regs[IDX_TAG][c*DAPC_TAG_W+:DAPC_TAG_W];
   end

   // ------------------------------------------------------------
   // lane serialiser
   // ------------------------------------------------------------
   dapc_ser_state_t ser_state;
   logic [63:0] sh_a;
   logic [31:0] sh_b;
   logic [6:0]  bits_left;
   logic [2:0]  lanes;
   logic        one_lane, narrow;
   logic [27:0] nar_a, nar_b;
   assign lanes    = regs[IDX_LANE][LANES_LSB+:3];
   assign one_lane = (lanes == LANES_1X20) || (lanes == LANES_1X24);
   assign narrow   = (lanes == LANES_2X20) || (lanes == LANES_1X20);
   // 20-bit mode keeps the top 20 data bits and the tag
   assign nar_a = {lane_word[0].data[23:4], lane_word[0].tag};
   assign nar_b = {lane_word[1].data[23:4], lane_word[1].tag};

   // a sample that arrives while a word is still going out is dropped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ser_state <= SER_IDLE;
         sh_a      <= '0;
         sh_b      <= '0;
         bits_left <= 7'h00;
         frame_out <= 1'b0;
      end else begin
         frame_out <= 1'b0;
         unique case (ser_state)
            SER_IDLE: begin
               if (avg_fire) begin
                  ser_state <= SER_SEND;
                  frame_out <= 1'b1;
                  bits_left <= one_lane ? 7'((narrow ? BITS_20 : BITS_24) << 1)
                                        : (narrow ? BITS_20 : BITS_24);
                  if (one_lane) begin
                     sh_a <= narrow ? {nar_a, nar_b, 8'h00}
                                    : {lane_word[0], lane_word[1]};
                     sh_b <= '0;
                  end else begin
                     sh_a <= narrow ? {nar_a, 36'h0} : {lane_word[0], 32'h0};
                     sh_b <= narrow ? {nar_b, 4'h0} : lane_word[1];
                  end
               end
            end
            SER_SEND: begin
               sh_a      <= {sh_a[62:0], 1'b0};
               sh_b      <= {sh_b[30:0], 1'b0};
               bits_left <= bits_left - 7'h01;
               if (bits_left == 7'h01) begin
                  ser_state <= SER_IDLE;
               end
            end
         endcase
      end
   end

   // lane pins are registered copies of the shifter heads
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lane_a_out <= 1'b0;
         lane_b_out <= 1'b0;
      end else begin
         lane_a_out <= (ser_state == SER_SEND) & sh_a[63];
         lane_b_out <= (ser_state == SER_SEND) & sh_b[31];
      end
   end

endmodule : dapc_output_path_bank

// *** verif/dapc_bank_sva.sv ***
// dapc_bank_sva: port-level checks of the output path config bank
`timescale 1ns/100ps
module dapc_bank_sva (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // config pins and lanes
   input wire logic       cfg_cs_n,
   input wire logic       cfg_sdo,
   input wire logic       conv_valid,
   input wire logic       frame_out,
   input wire logic       lane_a_out,
   input wire logic       lane_b_out,
   // control levels
   input wire logic       gain_trim_on,
   input wire logic       init_unlocked,
   input wire logic       sleep_a,
   input wire logic       sleep_b,
   input wire logic       lane_clock_cfg,
   input wire logic [1:0] averaging_prep,
   input wire logic [2:0] averaging_out_clock_cfg
);
   // --------------------
   // word spacing and checks
   // --------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [5:0] gap;
   // cycles since the last word start; saturates so a long idle never wraps
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap <= 6'h3F;
      end else begin
         gap <= frame_out ? 6'h01 : (gap == 6'h3F ? gap : gap + 6'h01);
      end
   end
   property p_rst_quiet;
      $fell(sys_rst) |-> !frame_out && !lane_a_out && !lane_b_out && !gain_trim_on
         && !init_unlocked && !sleep_a && !sleep_b;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   property p_frame_pulse; frame_out |=> !frame_out; endproperty
   a_frame_pulse: assert property (p_frame_pulse) else $error("word start held");
   property p_frame_cause; frame_out |-> $past(conv_valid); endproperty
   a_frame_cause: assert property (p_frame_cause) else $error("word with no sample");
   property p_frame_gap; frame_out |-> gap >= 6'd29; endproperty
   a_frame_gap: assert property (p_frame_gap) else $error("word cut short");
   property p_sdo_idle; cfg_cs_n [*5] |-> !cfg_sdo; endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("readback driven while idle");
   property p_gain_quiet;
      $changed(gain_trim_on) |-> $past(cfg_cs_n, 3) && !$past(cfg_cs_n, 9);
   endproperty
   a_gain_quiet: assert property (p_gain_quiet) else $error("trim moved off a frame");
   property p_key_quiet;
      $changed(init_unlocked) |-> $past(cfg_cs_n, 2) && $past(cfg_cs_n, 3);
   endproperty
   a_key_quiet: assert property (p_key_quiet) else $error("unlock moved off a frame");
   property p_lvl_quiet;
      $changed({sleep_b, sleep_a, lane_clock_cfg, averaging_prep, averaging_out_clock_cfg})
         |-> !$past(cfg_cs_n, 9);
   endproperty
   a_lvl_quiet: assert property (p_lvl_quiet) else $error("level moved off a frame");
   c_word: cover property (frame_out);
   c_unlock: cover property ($rose(init_unlocked));
   c_both_asleep: cover property (sleep_a && sleep_b);
endmodule : dapc_bank_sva
bind dapc_output_path_bank dapc_bank_sva chk_u (.clk, .sys_rst, .cfg_cs_n, .cfg_sdo,
   .conv_valid, .frame_out, .lane_a_out, .lane_b_out, .gain_trim_on, .init_unlocked,
   .sleep_a, .sleep_b, .lane_clock_cfg, .averaging_prep, .averaging_out_clock_cfg);

// *** verif/dapc_host_model.sv ***
// dapc_host_model: config frame master and lane word receiver
`timescale 1ns/100ps
module dapc_host_model (
   // clock
   input wire logic clk,
   // config pins
   output logic     cs_n,
   output logic     sclk,
   output logic     sdi,
   input wire logic sdo,
   // data lanes
   input wire logic lane_a,
   input wire logic lane_b,
   input wire logic frame
);
   // idle pins; the bank is always the selected one here
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // one frame msb first; 4 clk per phase beats the 3 clk synchroniser need
   task automatic xfer(input logic [23:0] f, output logic [23:0] r);
      int i;
      @(negedge clk);
      cs_n = 1'b0;
      for (i = 23; i >= 0; i--) begin
         sdi = f[i];
         repeat (4) @(negedge clk);
         r = {r[22:0], sdo};
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      sdi = ~sdi;  // released line keeps no stale value
      repeat (6) @(negedge clk);
   endtask : xfer
   // wait a bounded time for a word start, then shift in n lane bits
   task automatic grab(input int n, output logic [63:0] a, output logic [63:0] b,
                       output bit ok);
      int w;
      a = '0;
      b = '0;
      ok = 1'b0;
      // the word start may already stand when called right after the firing sample
      for (w = 0; w < 200 && !ok; w++) begin
         ok = (frame === 1'b1);
         if (!ok) @(negedge clk);
      end
      for (w = 0; w < n && ok; w++) begin
         @(negedge clk);
         a = {a[62:0], lane_a};
         b = {b[62:0], lane_b};
      end
   endtask : grab
endmodule : dapc_host_model

// *** verif/tb_top.sv ***
// tb_top: register, level and lane word checks of the output path bank
`timescale 1ns/100ps
module tb_top;
   import dapc_pkg::*;
   // --------------------
   // pins and tables
   // --------------------
   localparam logic [17:0] RES_A = 18'h2ABCD;
   localparam logic [17:0] RES_B = 18'h10F0E;
   localparam logic [23:0] PAT0 = 24'h781234;
   localparam logic [23:0] PAT1 = 24'h9ABC56;
   logic        clk, sys_rst, cfg_cs_n, cfg_sclk, cfg_sdi, cfg_sdo, conv_valid;
   logic        lane_a_out, lane_b_out, frame_out, gain_trim_on, init_unlocked;
   logic        sleep_a, sleep_b, lane_clock_cfg;
   logic [1:0]  averaging_prep;
   logic [2:0]  averaging_out_clock_cfg;
   logic [17:0] conv_a, conv_b;
   logic [9:0]  temp_sensor;
   logic [23:0] w1, w2;
   logic [63:0] ea, eb;
   int          miscompares, checks, i, k, nb;
   logic [15:0] key_val [5] = '{16'h0040, 16'h2000, 16'h0030, 16'h2070, 16'h0000};
   logic [1:0]  key_exp [5] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h0};
   logic [2:0]  lanes [4] = '{LANES_2X20, LANES_2X24, LANES_1X20, LANES_1X24};
   dapc_output_path_bank #(.RES_W(DAPC_RES_W)) dut_u (.clk, .sys_rst, .cfg_cs_n,
      .cfg_sclk, .cfg_sdi, .cfg_sdo, .conv_valid, .conv_a, .conv_b, .temp_sensor,
      .lane_a_out, .lane_b_out, .frame_out, .gain_trim_on, .init_unlocked, .sleep_a,
      .sleep_b, .lane_clock_cfg, .averaging_prep, .averaging_out_clock_cfg);
   dapc_host_model host_u (.clk, .cs_n(cfg_cs_n), .sclk(cfg_sclk), .sdi(cfg_sdi),
      .sdo(cfg_sdo), .lane_a(lane_a_out), .lane_b(lane_b_out), .frame(frame_out));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // --------------------
   // helpers
   // --------------------
   function automatic logic [23:0] wd(logic [17:0] r, logic twos, logic scr);
      logic [17:0] v;
      v = r;
      if (scr) v[17:1] = v[17:1] ^ {17{r[0]}};
      if (!twos) v[17] = ~v[17];
      return {v, 6'h00};
   endfunction : wd
   function automatic logic [63:0] mk(logic [23:0] d, logic [7:0] tag, logic w24);
      return w24 ? {32'h0, d, tag} : {36'h0, d[23:4], tag};
   endfunction : mk
   task automatic wrap_up;
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [23:0] r;
      host_u.xfer({a, d}, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] d);
      logic [23:0] r;
      host_u.xfer({READ_CMD, 8'h00, a}, r);
      host_u.xfer(24'hFFFFFF, r);
      chk(r, {a, d});
   endtask : rd
   task automatic fire(input logic [17:0] a, input logic [17:0] b);
      @(negedge clk);
      conv_a = a;
      conv_b = b;
      conv_valid = 1'b1;
      @(negedge clk);
      conv_valid = 1'b0;
   endtask : fire
   // a missing word start ends the run at once
   task automatic word(input int n, input logic [63:0] xa, input logic [63:0] xb,
                       output logic [23:0] wa);
      logic [63:0] a, b;
      bit ok;
      host_u.grab(n, a, b, ok);
      if (!ok) begin
         miscompares++;
         wrap_up();
      end else begin
         chk(a, xa);
         chk(b, xb);
         wa = a[31:8];
      end
   endtask : word
   // --------------------
   // main sequence
   // --------------------
   initial begin
      sys_rst = 1'b1;
      conv_valid = 1'b0;
      conv_a = '0;
      conv_b = '0;
      temp_sensor = 10'h2A5;
      miscompares = 0;
      checks = 0;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < DAPC_NUM_REGS; i++) begin
         rd(DAPC_OFFSET[i], i == 0 ? FMT_RESET : (i == 1 ? LANE_RESET : ZERO_RESET));
      end
      host_u.xfer({READ_CMD, 16'h0040}, w1);
      host_u.xfer(24'hFFFFFF, w1);
      chk(w1, 64'h0);
      wr(8'h0D, 16'h2082);
      chk(gain_trim_on, 1'b1);
      wr(8'h0D, FMT_RESET);
      for (i = 0; i < 5; i++) begin
         wr(8'h33, key_val[i]);
         chk({gain_trim_on, init_unlocked}, key_exp[i]);
      end
      for (i = 0; i < 4; i++) begin
         wr(8'hC0, {6'h00, 3'(i), 5'h00, 2'(i)});
         chk({sleep_b, sleep_a, averaging_out_clock_cfg}, {2'(i), 3'(i)});
      end
      // a second rise needs the bit cleared first
      wr(8'h90, 16'h4000);
      rd(8'h91, 16'h02A5);
      temp_sensor = 10'h15A;
      wr(8'h90, 16'h4000);
      rd(8'h91, 16'h02A5);
      wr(8'h90, 16'h0000);
      wr(8'h90, 16'h4000);
      rd(8'h91, 16'h015A);
      wr(8'h1C, 16'hB5A3);
      wr(8'h14, 16'h1234);
      wr(8'h15, 16'h5678);
      wr(8'h16, 16'h9ABC);
      wr(8'h19, 16'h4321);
      wr(8'h1A, 16'h0087);
      rd(8'h15, 16'h5678);
      for (i = 0; i < 4; i++) begin
         nb = lanes[i][1] ? 32 : 28;
         wr(8'h12, {13'h0000, lanes[i]});
         wr(8'hC0, {3'h0, lanes[i][2], 12'h000});
         chk(lane_clock_cfg, lanes[i][2]);
         fire(RES_A, RES_B);
         ea = mk(wd(RES_A, 1'b1, 1'b0), 8'hA3, lanes[i][1]);
         eb = mk(wd(RES_B, 1'b1, 1'b0), 8'hB5, lanes[i][1]);
         if (lanes[i][2]) word(2 * nb, (ea << nb) | eb, 64'h0, w1);
         else word(nb, ea, eb, w1);
      end
      for (i = 0; i < 4; i++) begin
         wr(8'h0D, {2'h0, i[0], 11'h000, 2'h2});
         wr(8'h12, {12'h000, i[1], LANES_2X24});
         fire(RES_A, RES_B);
         word(32, mk(wd(RES_A, i[0], i[1]), 8'hA3, 1'b1),
            mk(wd(RES_B, i[0], i[1]), 8'hB5, 1'b1), w1);
      end
      wr(8'h12, LANE_RESET);
      wr(8'h18, 16'h0002);
      eb = mk(24'h874321, 8'hB5, 1'b1);
      for (i = 0; i < 4; i++) begin
         wr(8'h13, {8'h00, 4'h3, 2'(i), 2'h2});
         fire(RES_A, RES_B);
         word(32, {32'h0, i == 2 ? 24'h000018 : PAT0, 8'hA3}, eb, w1);
         fire(RES_A, RES_B);
         word(32, {32'h0, i == 3 ? PAT1 : (i == 2 ? 24'h00001C : PAT0), 8'hA3}, eb, w2);
         if (i == 2) chk(24'(w2 - w1), 24'h000004);
      end
      wr(8'h13, 16'h0000);
      fire(RES_A, RES_B);
      word(32, mk(wd(RES_A, 1'b1, 1'b0), 8'hA3, 1'b1), eb, w1);
      wr(8'hC0, 16'h0400);
      chk(averaging_prep, 2'h1);
      wr(8'h18, 16'h0000);
      for (i = 0; i < 4; i++) begin
         wr(8'h0D, {2'h0, 1'b1, 6'h00, 1'b1, 2'h0, 2'(i), 2'h2});
         for (k = 0; k < (2 << i); k++) fire(18'(4 * k), 18'(4 * k));
         ea = mk(wd(18'(2 * (2 << i) - 2), 1'b1, 1'b0), 8'hA3, 1'b1);
         word(32, ea, {ea[63:8], 8'hB5}, w1);
      end
      wrap_up();
   end
endmodule : tb_top
